// file: rtl/hpp_port.v
`include "hpp_regs.vh"
// host parallel port: pin side toward the host, register side toward the core
module hpp_port (
  input wire clock,
  input wire rst,
  input wire hard_clear_in,
  input wire low_addr_or_latch,
  input wire addr_bit1,
  input wire addr_bit2,
  input wire addr_bit3,
  input wire [`HPP_DATA_W-1:0] shared_bus_in,
  output reg [`HPP_DATA_W-1:0] shared_bus_out,
  output reg shared_bus_oe_n,
  input wire rd_strobe_n,
  input wire wr_strobe_n,
  input wire chip_sel_n,
  output reg irq_out,
  output reg irq_oe_n,
  input wire [`HPP_IRQ_W-1:0] irq_pending,
  output reg [`HPP_ADDR_W-1:0] reg_addr,
  output reg [`HPP_DATA_W-1:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd,
  input wire [`HPP_DATA_W-1:0] reg_rdata,
  output reg [`HPP_MODE_W-1:0] bus_mode,
  output reg in_reset
);
  // in strobe mode rd_strobe_n is the data strobe, wr_strobe_n the direction
  localparam ST_IDLE = `HPP_ST_IDLE;
  localparam ST_ACC = `HPP_ST_ACC;
  localparam ST_END = `HPP_ST_END;

  wire clr_s, a0_s, a1_s, a2_s, a3_s, rd_s, wr_s, cs_s;
  wire [`HPP_DATA_W-1:0] bus_s;
  wire [`HPP_ADDR_W-1:0] mux_addr;
  reg [2:0] state;
  reg [2:0] next_state;
  reg ds_prev;
  reg is_read;
  reg access_on;
  reg access_read;
  reg [`HPP_ADDR_W-1:0] plain_addr;
  reg [1:0] strap;
  reg [`HPP_MODE_W-1:0] next_bus_mode;
  reg access_end;
  // helpers derived from the mode and the synced pins
  wire mode_mux;
  wire mode_strobe;
  wire ds_rise;
  wire [`HPP_ADDR_W-1:0] sel_addr;

  // every pin passes two flops before use
  // the clear pin ignores rst, so it alone can hold the core in reset
  hpp_sync #(
    .RST_VAL(`HPP_PIN_LOW)
  ) u_clr (
    .clock(clock),
    .rst(1'b0),
    .din(hard_clear_in),
    .dout(clr_s)
  );

  // address and strap pins rest low
  hpp_sync #(
    .RST_VAL(`HPP_PIN_LOW)
  ) u_a0 (
    .clock(clock),
    .rst(rst),
    .din(low_addr_or_latch),
    .dout(a0_s)
  );
  hpp_sync #(
    .RST_VAL(`HPP_PIN_LOW)
  ) u_a1 (
    .clock(clock),
    .rst(rst),
    .din(addr_bit1),
    .dout(a1_s)
  );
  hpp_sync #(
    .RST_VAL(`HPP_PIN_LOW)
  ) u_a2 (
    .clock(clock),
    .rst(rst),
    .din(addr_bit2),
    .dout(a2_s)
  );
  hpp_sync #(
    .RST_VAL(`HPP_PIN_LOW)
  ) u_a3 (
    .clock(clock),
    .rst(rst),
    .din(addr_bit3),
    .dout(a3_s)
  );

  // strobes and select rest high, so a reset never looks like an access
  hpp_sync #(
    .RST_VAL(`HPP_PIN_HIGH)
  ) u_rd (
    .clock(clock),
    .rst(rst),
    .din(rd_strobe_n),
    .dout(rd_s)
  );
  hpp_sync #(
    .RST_VAL(`HPP_PIN_HIGH)
  ) u_wr (
    .clock(clock),
    .rst(rst),
    .din(wr_strobe_n),
    .dout(wr_s)
  );
  hpp_sync #(
    .RST_VAL(`HPP_PIN_HIGH)
  ) u_cs (
    .clock(clock),
    .rst(rst),
    .din(chip_sel_n),
    .dout(cs_s)
  );

  // data bits synchronised in a loop of the same cell
  genvar gi;
  generate
    for (gi = 0; gi < `HPP_DATA_W; gi = gi + 1) begin : g_bus
      hpp_sync #(
        .RST_VAL(`HPP_PIN_LOW)
      ) u_b (
        .clock(clock),
        .rst(rst),
        .din(shared_bus_in[gi]),
        .dout(bus_s[gi])
      );
    end
  endgenerate

  // address phase; lowest bit is zero, so the index starts one bit up
  hpp_addr_latch u_latch (
    .clock(clock),
    .rst(rst | in_reset),
    .latch_en(a0_s & mode_mux),
    .bus_addr(bus_s[`HPP_MUX_ADDR_LSB +: `HPP_ADDR_W]),
    .addr(mux_addr)
  );

  // internal reset while the clear pin is high
  always @(posedge clock) begin
    if (rst) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= clr_s;
    end
  end

  // keep tracking the strap pins during reset, freeze after release
  always @(posedge clock) begin
    if (rst) begin
      strap <= `HPP_STRAP_PLAIN;
    end else if (in_reset) begin
      strap <= {a1_s, a0_s};
    end
  end

  always @* begin
    if (strap == `HPP_STRAP_STROBE) begin
      next_bus_mode = `HPP_MODE_STROBE;
    end else if (strap == `HPP_STRAP_PLAIN) begin
      next_bus_mode = `HPP_MODE_PLAIN;
    end else begin
      // either mixed pattern means the multiplexed bus
      next_bus_mode = `HPP_MODE_MUX;
    end
  end

  // mode register; the strap freezes when the clear ends, so this settles one edge later
  always @(posedge clock) begin
    if (rst) begin
      bus_mode <= `HPP_MODE_PLAIN;
    end else begin
      bus_mode <= next_bus_mode;
    end
  end

  // in plain mode the address lines give the register address
  always @* begin
    plain_addr = {a3_s, a2_s, a1_s, a0_s};
  end

  // mode flags picked out of the one-hot code
  assign mode_mux = bus_mode[`HPP_MODE_BIT_MUX];
  assign mode_strobe = bus_mode[`HPP_MODE_BIT_STROBE];

  // multiplexed address from the latch, plain from the pins
  assign sel_addr = mode_mux ? mux_addr : plain_addr;

  // rise of the data strobe, seen after the synchroniser
  assign ds_rise = rd_s && !ds_prev;

  // end of an access: strobe rise in strobe mode, strobe release otherwise
  always @* begin
    access_end = 1'b0;
    if (mode_strobe) begin
      access_end = ds_rise;
    end else begin
      access_end = !access_on;
    end
  end

  // access qualification per mode
  always @* begin
    access_on = 1'b0;
    access_read = 1'b0;
    if (!cs_s && !in_reset && !mode_strobe) begin
      // read strobe low; write strobe low
      access_on = !rd_s || !wr_s;
      access_read = !rd_s;
    end else if (!cs_s && !in_reset) begin
      access_on = !rd_s;
      access_read = wr_s;
    end
  end

  // access sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (access_on) begin
          next_state = ST_ACC;
        end
      end
      ST_ACC: begin
        // data strobe rise (or strobe release) closes the access
        if (access_end) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register and core-side strobes
  always @(posedge clock) begin
    if (rst || in_reset) begin
      state <= ST_IDLE;
      ds_prev <= `HPP_PIN_HIGH;
      is_read <= 1'b0;
      reg_addr <= {`HPP_ADDR_W{1'b0}};
      reg_wdata <= {`HPP_DATA_W{1'b0}};
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end else begin
      state <= next_state;
      ds_prev <= rd_s;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (state == ST_IDLE && access_on) begin
        is_read <= access_read;
        reg_addr <= sel_addr;
        reg_rd <= access_read;
      end
      // write data taken at the end of the strobe, when the host has it stable
      if (state == ST_ACC && next_state == ST_END && !is_read) begin
        reg_wdata <= bus_s;
        reg_wr <= 1'b1;
      end
    end
  end

  // drive the bus only during a read access
  always @(posedge clock) begin
    if (rst || in_reset) begin
      shared_bus_out <= {`HPP_DATA_W{1'b0}};
      shared_bus_oe_n <= 1'b1;
    end else if (state == ST_ACC && is_read && access_on) begin
      shared_bus_out <= reg_rdata;
      shared_bus_oe_n <= 1'b0;
    end else begin
      // the output register keeps the last read value; only the enable decides the pins
      shared_bus_oe_n <= 1'b1;
    end
  end

  // outside reset, pull low while any request pends; level until all cleared
  always @(posedge clock) begin
    if (rst || in_reset) begin
      irq_oe_n <= 1'b1;
    end else begin
      // the core owns the flags; the port only mirrors whether any is set
      irq_oe_n <= ~(|irq_pending);
    end
  end

  // open drain, the driven level is always low
  always @(posedge clock) begin
    irq_out <= 1'b0;
  end
endmodule // hpp_port

// file: rtl/hpp_regs.vh
`ifndef HPP_REGS_VH
`define HPP_REGS_VH
`define HPP_MODE_W 3
`define HPP_MODE_STROBE 3'h4
`define HPP_MODE_PLAIN 3'h1
`define HPP_MODE_MUX 3'h2
`define HPP_MODE_BIT_MUX 1
`define HPP_MODE_BIT_STROBE 2
`define HPP_PIN_LOW 1'b0
`define HPP_PIN_HIGH 1'b1
`define HPP_STRAP_STROBE 2'h3
`define HPP_STRAP_PLAIN 2'h0
`define HPP_ADDR_W 4
`define HPP_DATA_W 8
`define HPP_IRQ_W 8
`define HPP_MUX_ADDR_LSB 1
`define HPP_ST_IDLE 3'h1
`define HPP_ST_ACC 3'h2
`define HPP_ST_END 3'h4
`endif

// file: rtl/hpp_sync.v
// two-stage synchroniser; first stage feeds only the second
module hpp_sync #(
  parameter RST_VAL = 1'b1
) (
  input wire clock,
  input wire rst,
  input wire din,
  output reg dout
);
  reg meta;

  // plain double flop, reset to the idle level of the pin
  always @(posedge clock) begin
    if (rst) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // hpp_sync

// file: rtl/hpp_addr_latch.v
`include "hpp_regs.vh"
// address latch for the multiplexed mode
module hpp_addr_latch (
  input wire clock,
  input wire rst,
  input wire latch_en,
  input wire [`HPP_ADDR_W-1:0] bus_addr,
  output wire [`HPP_ADDR_W-1:0] addr
);
  reg [`HPP_ADDR_W-1:0] held;

  always @(posedge clock) begin
    if (rst) begin
      held <= {`HPP_ADDR_W{1'b0}};
    end else if (latch_en) begin
      held <= bus_addr;
    end
  end

  assign addr = latch_en ? bus_addr : held;
endmodule // hpp_addr_latch

// file: verif/hpp_host_model.sv
// host side of the port: every pin changes only at a falling edge
module hpp_host_model (
  input wire clock,
  output logic ale,
  output logic a1,
  output logic a2,
  output logic a3,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  output logic [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [7:0] dv = 8'h00;
  // a released bus shows the inverse, so a stale copy is never read back
  assign bus = drv ? dv : ~dv;
  initial {ale, a1, a2, a3, rd_n, wr_n, cs_n} = 7'h07;
  // strap levels on two lowest pins
  task strap(input [1:0] s);
    {a1, ale} = s;
  endtask
  task acc(input [2:0] m, input w, input c, input [3:0] a, input [7:0] d);
    @(negedge clock);
    // even address first, latch closed before data
    if (m == 3'h2) begin
      ale = 1'b1;
      dv = {3'h0, a, 1'b0};
      drv = 1'b1;
      repeat (4) @(negedge clock);
      ale = 1'b0;
      repeat (4) @(negedge clock);
    end else begin
      {a3, a2, a1, ale} = a;
    end
    cs_n = !c;
    dv = d;
    drv = w;
    wr_n = !w;
    rd_n = (m == 3'h4) ? 1'b0 : w;
    repeat (8) @(negedge clock);
    // strobe rise ends it; direction held one cycle longer
    rd_n = 1'b1;
    @(negedge clock);
    wr_n = 1'b1;
    repeat (4) @(negedge clock);
    cs_n = 1'b1;
    drv = 1'b0;
    repeat (3) @(negedge clock);
  endtask
endmodule // hpp_host_model

// file: verif/hpp_port_checker.sv
// watches pulses, bus drive and interrupt line of the port
module hpp_port_checker (
  input wire clock,
  input wire rst,
  input wire hard_clear_in,
  input wire chip_sel_n,
  input wire [7:0] irq_pending,
  input wire irq_out,
  input wire irq_oe_n,
  input wire shared_bus_oe_n,
  input wire reg_rd,
  input wire reg_wr,
  input wire [2:0] bus_mode,
  input wire in_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_irq_no_high: assert property (!irq_out) else $error("irq drives high");
  chk_irq_pull: assert property ((|irq_pending && !in_reset)[*3] |-> !irq_oe_n)
    else $error("irq not pulled");
  chk_irq_free: assert property ((irq_pending == 8'h00)[*3] |-> irq_oe_n) else $error("irq stuck");
  chk_drive_cause: assert property ($fell(shared_bus_oe_n) |-> $past(reg_rd))
    else $error("bus driven without read");
  chk_rd_pulse: assert property (reg_rd |=> !reg_rd) else $error("read pulse long");
  chk_wr_pulse: assert property (reg_wr |=> !reg_wr) else $error("write pulse long");
  chk_cs_gate: assert property (reg_rd |-> !$past(chip_sel_n, 3)) else $error("read unselected");
  chk_clear_hold: assert property (hard_clear_in[*4] |-> in_reset) else $error("clear ignored");
  chk_mode_fixed: assert property (!in_reset && !$past(in_reset) |-> $stable(bus_mode))
    else $error("mode changed");
  cover property (reg_wr);
  cover property (!shared_bus_oe_n);
  cover property (!irq_oe_n);
  cover property (reg_rd && bus_mode == 3'h4);
endmodule // hpp_port_checker
bind hpp_port hpp_port_checker u_chk (.clock(clock), .rst(rst), .hard_clear_in(hard_clear_in),
  .chip_sel_n(chip_sel_n), .irq_pending(irq_pending), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
  .shared_bus_oe_n(shared_bus_oe_n), .reg_rd(reg_rd), .reg_wr(reg_wr), .bus_mode(bus_mode),
  .in_reset(in_reset));

// file: verif/test_host_parallel_bus_port.sv
// bench: host model on the pins, bench plays the register core
module test_host_parallel_bus_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst = 1'b1, hard_clear_in = 1'b1;
  logic [7:0] irq_pending = 8'h00, reg_rdata = 8'h00;
  logic [31:0] rnd = 32'h41ff_03f6;
  int miscompares = 0, n_compared = 0, s;
  wire ale, a1, a2, a3, rd_n, wr_n, cs_n, irq_out, irq_oe_n, sbo_oe_n, reg_wr, reg_rd, in_reset;
  wire [7:0] hbus, sbo, reg_wdata;
  wire [3:0] reg_addr;
  wire [2:0] bus_mode;
  // wire level seen by both ends; the irq line has a pull-up
  wire [7:0] sbus = !sbo_oe_n ? sbo : hbus;
  wire irq_line = irq_oe_n ? 1'b1 : irq_out;
  always #4 clock = !clock;
  hpp_host_model h (.clock(clock), .ale(ale), .a1(a1), .a2(a2), .a3(a3), .rd_n(rd_n), .wr_n(wr_n),
    .cs_n(cs_n), .bus(hbus));
  hpp_port dut (.clock(clock), .rst(rst), .hard_clear_in(hard_clear_in), .low_addr_or_latch(ale),
    .addr_bit1(a1), .addr_bit2(a2), .addr_bit3(a3), .shared_bus_in(sbus), .shared_bus_out(sbo),
    .shared_bus_oe_n(sbo_oe_n), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .chip_sel_n(cs_n),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .irq_pending(irq_pending), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_mode(bus_mode), .in_reset(in_reset));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [2:0] mode_of(input [1:0] p);
    mode_of = (p == 2'h3) ? 3'h4 : (p == 2'h0) ? 3'h1 : 3'h2;
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // strap is held well past the clear release, then moved away
  task boot(input [1:0] p);
    @(negedge clock);
    rst = 1'b1;
    hard_clear_in = 1'b1;
    h.strap(p);
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    chk(in_reset, 1'b1);
    hard_clear_in = 1'b0;
    repeat (6) @(negedge clock);
    chk(in_reset, 1'b0);
    h.strap(2'h0);
    repeat (6) @(negedge clock);
    chk(bus_mode, mode_of(p));
  endtask
  // a missing pulse within the bounded watch counts as a mismatch
  task xfer(input [2:0] m, input w, input c, input [3:0] a, input [7:0] d);
    int k;
    logic got;
    logic drove;
    got = 1'b0;
    drove = 1'b0;
    fork
      h.acc(m, w, c, a, d);
      for (k = 0; k < 40; k++) begin
        @(posedge clock);
        #1;
        if (reg_wr || reg_rd) begin
          got = 1'b1;
          chk({reg_rd, reg_addr}, {!w, a});
        end
        if (reg_wr) chk(reg_wdata, d);
        if (!sbo_oe_n) begin
          drove = 1'b1;
          chk(sbus, reg_rdata);
        end
      end
    join
    chk(got, c);
    chk(drove, c && !w);
    chk(sbo_oe_n, 1'b1);
  endtask
  initial begin
    for (s = 0; s < 4; s++) begin
      boot(s[1:0]);
      repeat (4) begin
        @(negedge clock);
        rnd = lfsr(rnd);
        reg_rdata = rnd[23:16];
        xfer(mode_of(s[1:0]), rnd[0], 1'b1, rnd[7:4], rnd[15:8]);
      end
      xfer(mode_of(s[1:0]), 1'b1, 1'b1, 4'hf, 8'h00);
      xfer(mode_of(s[1:0]), rnd[1], 1'b0, 4'h0, 8'hff);
    end
    @(negedge clock);
    irq_pending = rnd[7:0] | 8'h01;
    repeat (5) @(negedge clock);
    chk(irq_line, 1'b0);
    irq_pending = 8'h01;
    repeat (5) @(negedge clock);
    chk(irq_line, 1'b0);
    irq_pending = 8'h00;
    repeat (5) @(negedge clock);
    chk(irq_line, 1'b1);
    close_out;
  end
endmodule // test_host_parallel_bus_port
